// File: logic/vme_slave_window_decoder.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module vme_slave_window_decoder
(
  // Clock, reset and clock enable.
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  // Register bus.
  input  wire vme_window_pkg::axi_req_s   axi_req,
  output var  vme_window_pkg::axi_rsp_s   axi_rsp,
  // Inbound VMEbus cycle from the pins.
  input  wire vme_window_pkg::vme_cycle_s vme_cycle,
  // Decode result toward the local bus.
  output var  vme_window_pkg::local_out_s local_out
);
  import vme_window_pkg::*;

  state_s s_r;
  state_s s_nxt;

  logic        aw_ready;
  logic        w_ready;
  logic        ar_ready;
  logic [15:0] vme_hi;
  logic [15:0] end_bound;
  logic [15:0] start_bound;
  logic [15:0] offset;
  logic [15:0] mask;
  logic [7:0]  am_sel;
  logic [1:0]  snoop;
  logic        kind_ok;
  logic        width_ok;
  logic        priv_ok;
  logic        groups_ok;
  logic        in_range;
  logic [15:0] sum_hi;
  logic [15:0] repl_hi;

  // Merges written bytes into a register, keeping only its writable bits.
  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] wr_val,
                                        input logic [3:0]  strb,
                                        input logic [31:0] wr_mask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wr_mask;
    return (old_val & ~lanes) | (wr_val & lanes);
  endfunction

  // Register slots behind the bus; any other address is unmapped.
  typedef enum logic [2:0] {
    SLOT_BOUND,
    SLOT_W1_XLATE,
    SLOT_W2_XLATE,
    SLOT_CTRL,
    SLOT_CFG,
    SLOT_STAT,
    SLOT_NONE
  } slot_e;

  // Maps a byte address onto its slot; the write, the read and both answer codes share it.
  function automatic slot_e slot_of(input logic [31:0] addr);
    slot_e slot;
    unique case (addr)
      W2_BOUND_ADDR:
      begin
        slot = SLOT_BOUND;
      end
      W1_XLATE_ADDR:
      begin
        slot = SLOT_W1_XLATE;
      end
      W2_XLATE_ADDR:
      begin
        slot = SLOT_W2_XLATE;
      end
      W2_CTRL_ADDR:
      begin
        slot = SLOT_CTRL;
      end
      BLOCK_CFG_ADDR:
      begin
        slot = SLOT_CFG;
      end
      BLOCK_STAT_ADDR:
      begin
        slot = SLOT_STAT;
      end
      default:
      begin
        slot = SLOT_NONE;
      end
    endcase
    return slot;
  endfunction

  // Snoop request per processor kind: the first kind snoops on the two dirty-source codes,
  // the second kind on both codes whose low bit is clear; code three never snoops.
  function automatic logic snoop_on(input logic [1:0] code,
                                    input logic       second_kind);
    logic on;
    unique case (code)
      2'h0:
      begin
        on = second_kind;
      end
      2'h1:
      begin
        on = !second_kind;
      end
      2'h2:
      begin
        on = 1'b1;
      end
      2'h3:
      begin
        on = 1'b0;
      end
    endcase
    return on;
  endfunction

  slot_e wr_slot;
  slot_e rd_slot;

  // Slot of the held write address and of the offered read address.
  assign wr_slot = slot_of(s_r.aw_addr);
  assign rd_slot = slot_of(axi_req.araddr);

  // Handshake readies: one write and one read at a time, held low while the clock enable is low.
  assign aw_ready = ce && !s_r.aw_full && !s_r.bvalid;
  assign w_ready  = ce && !s_r.w_full && !s_r.bvalid;
  assign ar_ready = ce && !s_r.rvalid;

  // Bus answer assembled from flops and readies.
  always_comb
  begin
    axi_rsp.awready = aw_ready;
    axi_rsp.wready  = w_ready;
    axi_rsp.bvalid  = s_r.bvalid;
    axi_rsp.bresp   = s_r.bresp;
    axi_rsp.arready = ar_ready;
    axi_rsp.rvalid  = s_r.rvalid;
    axi_rsp.rdata   = s_r.rdata;
    axi_rsp.rresp   = s_r.rresp;
  end

  assign local_out = s_r.out;

  // Field views of the registers and of the settled cycle.
  assign end_bound   = s_r.w2_bound[31:HALF_HI_LSB];
  assign start_bound = s_r.w2_bound[HALF_HI_LSB-1:0];
  assign offset      = s_r.w2_xlate[31:HALF_HI_LSB];
  assign mask        = s_r.w2_xlate[HALF_HI_LSB-1:0];
  assign am_sel      = s_r.w2_ctrl[AM_LSB +: 8];
  assign snoop       = s_r.w2_ctrl[SNOOP_LSB +: 2];

  // A24 cycles see their upper eight address bits as zero.
  assign vme_hi = s_r.cyc.a24 ? {8'h00, s_r.cyc.addr[23:16]} : s_r.cyc.addr[31:16];

  // Cycle kind, address width and privilege matched against the enables.
  always_comb
  begin
    if (s_r.cyc.d64)
    begin
      kind_ok = am_sel[AM_D64];
    end
    else if (s_r.cyc.block)
    begin
      kind_ok = am_sel[AM_BLOCK];
    end
    else if (s_r.cyc.program_access)
    begin
      kind_ok = am_sel[AM_PROGRAM];
    end
    else
    begin
      kind_ok = am_sel[AM_OPERAND];
    end
    width_ok = s_r.cyc.a24 ? am_sel[AM_A24] : am_sel[AM_A32];
    priv_ok  = s_r.cyc.privileged ? am_sel[AM_PRIV] : am_sel[AM_NONPRIV];
  end

  // Each group needs one enable set, so a cleared select turns the window off.
  assign groups_ok = (|am_sel[AM_D64:AM_OPERAND]) && (|am_sel[AM_A32:AM_A24]) &&
                     (|am_sel[AM_PRIV:AM_NONPRIV]);
  assign in_range  = (vme_hi >= start_bound) && (vme_hi <= end_bound);

  // Both translation forms of the upper local address half.
  assign sum_hi  = offset + vme_hi;
  assign repl_hi = (offset & mask) | (vme_hi & ~mask);

  // Next state of registers, bus slave, pin synchronisers and decode outputs.
  always_comb
  begin
    s_nxt = s_r;

    // Write address and data are taken in either order.
    if (axi_req.awvalid && aw_ready)
    begin
      s_nxt.aw_addr = axi_req.awaddr;
      s_nxt.aw_full = 1'b1;
    end
    if (axi_req.wvalid && w_ready)
    begin
      s_nxt.w_data = axi_req.wdata;
      s_nxt.w_strb = axi_req.wstrb;
      s_nxt.w_full = 1'b1;
    end

    // Once both halves are held, the write lands and the answer is raised.
    if (s_r.aw_full && s_r.w_full)
    begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = (wr_slot == SLOT_NONE) ? RESP_DECERR : RESP_OKAY;
      unique case (wr_slot)
        SLOT_BOUND:
          s_nxt.w2_bound = merge(s_r.w2_bound, s_r.w_data, s_r.w_strb,
                                 FULL_WORD_MASK);
        SLOT_W1_XLATE:
          s_nxt.w1_xlate = merge(s_r.w1_xlate, s_r.w_data, s_r.w_strb,
                                 FULL_WORD_MASK);
        SLOT_W2_XLATE:
          s_nxt.w2_xlate = merge(s_r.w2_xlate, s_r.w_data, s_r.w_strb,
                                 FULL_WORD_MASK);
        SLOT_CTRL:
          s_nxt.w2_ctrl = merge(s_r.w2_ctrl, s_r.w_data, s_r.w_strb,
                                W2_CTRL_WR_MASK);
        SLOT_CFG:
          s_nxt.cfg = merge(s_r.cfg, s_r.w_data, s_r.w_strb, CFG_WR_MASK);
        SLOT_STAT, SLOT_NONE:
        begin
          s_nxt.cfg = s_r.cfg;
        end
      endcase
    end
    if (s_r.bvalid && axi_req.bready)
    begin
      s_nxt.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken.
    if (axi_req.arvalid && ar_ready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = (rd_slot == SLOT_NONE) ? RESP_DECERR : RESP_OKAY;
      unique case (rd_slot)
        SLOT_BOUND:    s_nxt.rdata = s_r.w2_bound;
        SLOT_W1_XLATE: s_nxt.rdata = s_r.w1_xlate;
        SLOT_W2_XLATE: s_nxt.rdata = s_r.w2_xlate;
        SLOT_CTRL:     s_nxt.rdata = s_r.w2_ctrl;
        SLOT_CFG:      s_nxt.rdata = s_r.cfg;
        SLOT_STAT:     s_nxt.rdata = {s_r.out.addr[31:16], 15'h0000, s_r.out.hit};
        SLOT_NONE:     s_nxt.rdata = REG_RESET;
      endcase
    end
    else if (s_r.rvalid && axi_req.rready)
    begin
      s_nxt.rvalid = 1'b0;
    end

    // Pins pass three stages; a value counts once the second and third agree.
    s_nxt.sync1 = vme_cycle;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    if (s_r.sync2 == s_r.sync3)
    begin
      s_nxt.cyc = s_r.sync3;
    end

    // Decode of the settled cycle, registered toward the local bus.
    s_nxt.out.hit = s_r.cyc.strobe && groups_ok && kind_ok && width_ok &&
                    priv_ok && in_range;
    if (s_r.w2_ctrl[ADDER_BIT])
    begin
      s_nxt.out.addr = {sum_hi, s_r.cyc.addr[15:0]};
    end
    else
    begin
      s_nxt.out.addr = {repl_hi, s_r.cyc.addr[15:0]};
    end
    s_nxt.out.post_write = s_nxt.out.hit && s_r.cyc.write &&
                           s_r.w2_ctrl[POST_BIT];
    s_nxt.out.snoop_code   = snoop;
    s_nxt.out.snoop_enable = snoop_on(snoop, s_r.cfg[CPU_KIND_BIT]);
  end

  // State register; everything clears on reset and holds while the enable is low.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

endmodule
`default_nettype wire

// File: logic/vme_window_pkg.sv
// Overview of operation
// - The second window's end bound sits in bits 31..16 of its bound word, read/write, zero at reset.
// - The second window's start bound sits in bits 15..0 of the same word, read/write, zero at reset.
// - The first window's translation word top half holds the local start, and is the sum offset when the adder is on; this design only stores it and reads it back.
// - The second window's translation word top half holds the local start, and is the sum offset when its adder is on.
// - With the post bit set, writes that hit the second window are posted; with it clear they are not.
// - For the first processor kind the two snoop bits drive 00 off, 01 sink, 10 invalidate, 11 off.
// - For the second processor kind snoop codes 00 and 10 enable snooping and 01 and 11 disable it.
// - With the adder bit set the local address is a sum; with it clear it is formed by replacement.
// - Only four bits of the second window's control byte are used; the upper four read zero; all clear at reset.
// - Bits 23..16 enable privileged, nonprivileged, A32, A24, D64, block, program and operand cycles.
// - A window decodes only with at least one enable set in each of the kind, width and privilege groups.
// - In sum mode local bits 31..16 are offset plus address bits 31..16, with bits 31..24 zeroed for A24.
// - In replacement mode each set mask bit takes the translation bit, each clear one the incoming bit.
// - For A24 cycles the upper eight incoming address bits are zeroed before the bound compare.
package vme_window_pkg;

  // Register byte addresses.
  localparam logic [31:0] W2_BOUND_ADDR = 32'hFFF40004;
  localparam logic [31:0] W1_XLATE_ADDR = 32'hFFF40008;
  localparam logic [31:0] W2_XLATE_ADDR = 32'hFFF4000C;
  localparam logic [31:0] W2_CTRL_ADDR  = 32'hFFF40010;
  localparam logic [31:0] BLOCK_CFG_ADDR  = 32'hFFF40080;
  localparam logic [31:0] BLOCK_STAT_ADDR = 32'hFFF40084;

  // Value after reset and writable bits of each word.
  localparam logic [31:0] REG_RESET       = 32'h00000000;
  localparam logic [31:0] FULL_WORD_MASK  = 32'hFFFFFFFF;
  localparam logic [31:0] W2_CTRL_WR_MASK = 32'h0FFF0000;
  localparam logic [31:0] CFG_WR_MASK     = 32'h00000001;

  // Field positions.
  localparam int HALF_HI_LSB  = 16;
  localparam int POST_BIT     = 24;
  localparam int SNOOP_LSB    = 25;
  localparam int ADDER_BIT    = 27;
  localparam int AM_LSB       = 16;
  localparam int AM_OPERAND   = 0;
  localparam int AM_PROGRAM   = 1;
  localparam int AM_BLOCK     = 2;
  localparam int AM_D64       = 3;
  localparam int AM_A24       = 4;
  localparam int AM_A32       = 5;
  localparam int AM_NONPRIV   = 6;
  localparam int AM_PRIV      = 7;
  localparam int CPU_KIND_BIT = 0;

  // Bus answer codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Master to slave signals of the register bus.
  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_s;

  // Slave to master signals of the register bus.
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

  // Decoded inbound VMEbus cycle.
  typedef struct packed {
    logic        strobe;
    logic        write;
    logic        a24;
    logic        privileged;
    logic        program_access;
    logic        block;
    logic        d64;
    logic [31:0] addr;
  } vme_cycle_s;

  // Result of the window decode toward the local bus.
  typedef struct packed {
    logic        hit;
    logic [31:0] addr;
    logic        post_write;
    logic        snoop_enable;
    logic [1:0]  snoop_code;
  } local_out_s;

  // Whole state of the decoder.
  typedef struct packed {
    logic [31:0] w2_bound;
    logic [31:0] w1_xlate;
    logic [31:0] w2_xlate;
    logic [31:0] w2_ctrl;
    logic [31:0] cfg;
    logic [31:0] aw_addr;
    logic        aw_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_full;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    vme_cycle_s  sync1;
    vme_cycle_s  sync2;
    vme_cycle_s  sync3;
    vme_cycle_s  cyc;
    local_out_s  out;
  } state_s;

endpackage

// File: tb/vme_window_props.sv
`timescale 1ns/1ps
`default_nettype none
module vme_window_props
(
  // Clock, reset and clock enable.
  input wire logic                       sys_clk,
  input wire logic                       rst,
  input wire logic                       ce,
  // Register bus.
  input wire vme_window_pkg::axi_req_s   axi_req,
  input wire vme_window_pkg::axi_rsp_s   axi_rsp,
  // Pins and decode result.
  input wire vme_window_pkg::vme_cycle_s vme_cycle,
  input wire vme_window_pkg::local_out_s local_out
);
  import vme_window_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Both halves of a write taken at one edge.
  sequence wr_taken;
    ce && axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  // Read address taken.
  sequence rd_taken;
    ce && axi_req.arvalid && axi_rsp.arready;
  endsequence
  a_write_answer: assert property (wr_taken |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
    else $error("write answer not two edges after take");
  a_read_answer: assert property (rd_taken |=> axi_rsp.rvalid)
    else $error("read answer not one edge after take");
  a_resp_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
  a_read_blocked: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while answer pending");
  a_post_needs_hit: assert property (local_out.post_write |-> local_out.hit)
    else $error("posting without hit");
  a_snoop_reserved: assert property (local_out.snoop_code == 2'h3 |-> !local_out.snoop_enable)
    else $error("reserved snoop code enabled");
  a_snoop_invalid: assert property (local_out.snoop_code == 2'h2 |-> local_out.snoop_enable)
    else $error("snoop code two not enabled");
endmodule
bind vme_slave_window_decoder vme_window_props u_props (.sys_clk(sys_clk), .rst(rst), .ce(ce),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .vme_cycle(vme_cycle), .local_out(local_out));
`default_nettype wire

// File: tb/vme_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module vme_master_model
(
  // Clock.
  input wire logic                       sys_clk,
  // Cycle asked for by the bench.
  input wire vme_window_pkg::vme_cycle_s want,
  // Pins toward the decoder.
  output var vme_window_pkg::vme_cycle_s pins
);
  import vme_window_pkg::*;
  logic [31:0] last_addr;
  vme_cycle_s  held;
  initial pins = '0;
  initial last_addr = '0;
  // Drives the asked cycle; a released bus holds the inverse of the last address it carried.
  always @(posedge sys_clk)
  begin
    held = want;
    if (want.strobe) last_addr <= want.addr;
    else held.addr = ~last_addr;
    pins <= held;
  end
endmodule
`default_nettype wire

// File: tb/vme_slave_window_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module vme_slave_window_decoder_test;
  import vme_window_pkg::*;
  logic       sys_clk, rst, ce, look;
  axi_req_s   axi_req;
  axi_rsp_s   axi_rsp;
  vme_cycle_s want, pins, cy;
  local_out_s local_out, eo;
  int         error_cnt, num_checks;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  local_out_s  oq[$];
  logic [31:0] s, bnd, xl, ctl, cfg;
  logic [31:0] regs[5] = '{W2_BOUND_ADDR, W1_XLATE_ADDR, W2_XLATE_ADDR, W2_CTRL_ADDR, BLOCK_CFG_ADDR};
  logic [15:0] his[4] = '{16'h0010, 16'h10FF, 16'h1100, 16'hAB0F};

  vme_slave_window_decoder u_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .vme_cycle(pins), .local_out(local_out));
  vme_master_model u_far (.sys_clk(sys_clk), .want(want), .pins(pins));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Expected decode of one cycle from the programmed words.
  function automatic local_out_s exp_out(input vme_cycle_s c);
    logic [15:0] a;
    logic        k;
    local_out_s  o;
    a = c.addr[31:16];
    if (c.a24) a[15:8] = 8'h00;
    k = c.d64 ? ctl[19] : c.block ? ctl[18] : c.program_access ? ctl[17] : ctl[16];
    o.hit = c.strobe & k & (c.a24 ? ctl[20] : ctl[21]) & (c.privileged ? ctl[23] : ctl[22])
      & (a >= bnd[15:0]) & (a <= bnd[31:16]);
    o.addr[31:16] = ctl[27] ? a + xl[31:16] : (xl[31:16] & xl[15:0]) | (a & ~xl[15:0]);
    o.addr[15:0] = c.addr[15:0];
    o.post_write = o.hit & c.write & ctl[24];
    o.snoop_code = ctl[26:25];
    o.snoop_enable = cfg[0] ? !ctl[25] : ^ctl[26:25];
    return o;
  endfunction

  task automatic chk_rsp(input logic [33:0] g, input logic [33:0] e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("FAIL %0t bus got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_out(input local_out_s g, input local_out_s e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("FAIL %0t decode got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [31:0] ad, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, at, wt, b;
    bq.push_back(er);
    @(posedge sys_clk);
    axi_req.awaddr <= ad;
    axi_req.wdata <= d;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w)
    begin
      @(negedge sys_clk);
      at = aw && axi_rsp.awready;
      wt = w && axi_rsp.wready;
      @(posedge sys_clk);
      if (at) axi_req.awvalid <= 1'b0;
      if (wt) axi_req.wvalid <= 1'b0;
      aw = aw && !at;
      w = w && !wt;
    end
    do
    begin
      @(negedge sys_clk);
      b = axi_rsp.bvalid;
      @(posedge sys_clk);
    end while (!b);
    // The answer is left waiting one edge so that its hold is exercised.
    axi_req.bready <= 1'b1;
    @(posedge sys_clk);
    axi_req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] ad, input logic [33:0] e);
    logic t;
    rq.push_back(e);
    @(posedge sys_clk);
    axi_req.araddr <= ad;
    axi_req.arvalid <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      t = axi_rsp.arready;
      @(posedge sys_clk);
    end while (!t);
    axi_req.arvalid <= 1'b0;
    do
    begin
      @(negedge sys_clk);
      t = axi_rsp.rvalid;
      @(posedge sys_clk);
    end while (!t);
    axi_req.rready <= 1'b1;
    @(posedge sys_clk);
    axi_req.rready <= 1'b0;
  endtask

  task automatic probe(input vme_cycle_s c);
    oq.push_back(exp_out(c));
    @(posedge sys_clk);
    want <= c;
    repeat (8) @(posedge sys_clk);
    look <= 1'b1;
    @(posedge sys_clk);
    look <= 1'b0;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Clock of 4 ns.
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Takes the oldest note whenever a result shows at the outputs.
  always @(negedge sys_clk)
  begin
    if (axi_rsp.rvalid && axi_req.rready) chk_rsp({axi_rsp.rresp, axi_rsp.rdata}, rq.pop_front());
    if (axi_rsp.bvalid && axi_req.bready) chk_rsp({axi_rsp.bresp, 32'h0}, {bq.pop_front(), 32'h0});
    if (look) chk_out(local_out, oq.pop_front());
  end

  // Cuts a hang short.
  initial
  begin
    repeat (6000) @(posedge sys_clk);
    error_cnt++;
    stop_test();
  end

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    look = 1'b0;
    axi_req = '0;
    axi_req.wstrb = 4'hF;
    want = '0;
    s = 32'h78F0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (regs[i]) rd(regs[i], {RESP_OKAY, REG_RESET});
    rd(32'hFFF40020, {RESP_DECERR, 32'h0});
    wr(32'hFFF40020, FULL_WORD_MASK, RESP_DECERR);
    wr(W2_CTRL_ADDR, FULL_WORD_MASK, RESP_OKAY);
    rd(W2_CTRL_ADDR, {RESP_OKAY, W2_CTRL_WR_MASK});
    s = lfsr(s);
    wr(W2_BOUND_ADDR, s, RESP_OKAY);
    rd(W2_BOUND_ADDR, {RESP_OKAY, s});
    wr(W1_XLATE_ADDR, ~s, RESP_OKAY);
    rd(W1_XLATE_ADDR, {RESP_OKAY, ~s});
    $display("register test done");
    bnd = 32'h10FF0010;
    xl = {s[31:16], 16'hE000};
    wr(W2_BOUND_ADDR, bnd, RESP_OKAY);
    wr(W2_XLATE_ADDR, xl, RESP_OKAY);
    for (int i = 0; i < 32; i++)
    begin
      s = lfsr(s);
      ctl = {4'h0, s[3:0], s[11:4] | {8{s[12]}}, 16'h0};
      cfg = {31'h0, s[13]};
      wr(W2_CTRL_ADDR, ctl, RESP_OKAY);
      wr(BLOCK_CFG_ADDR, cfg, RESP_OKAY);
      cy = '{1'b1, s[14], s[15], s[16], s[17], s[18], s[19], {his[s[21:20]], s[31:16]}};
      eo = exp_out(cy);
      probe(cy);
      rd(BLOCK_STAT_ADDR, {RESP_OKAY, eo.addr[31:16], 15'h0000, eo.hit});
    end
    $display("decode test done");
    stop_test();
  end
endmodule
`default_nettype wire
